// ===== verilog/npw_pkg.sv
// Purpose: Shared constants and types of the four-pin port with wake and carrier
// Assumes: Core register port with 8-bit address and 4-bit data
// Notes:   Option straps are sampled while reset is held
package npw_pkg;
  localparam int          DW          = 4;
  localparam int          AW          = 8;
  localparam logic [7:0]  OFF_DIR     = 8'h02;
  localparam logic [7:0]  OFF_DATA    = 8'h03;
  localparam logic [7:0]  OFF_STAT    = 8'h04;
  localparam logic [7:0]  OFF_CLR     = 8'h05;
  localparam logic [7:0]  OFF_IEN     = 8'h06;
  localparam logic [3:0]  DIR_RST     = 4'h0;
  localparam logic [3:0]  DATA_RST    = 4'h0;
  localparam logic [3:0]  IEN_RST     = 4'h0;
  localparam logic [3:0]  STAT_RST    = 4'h0;
  localparam int          CARRIER_PIN = 3;
  localparam int          ANALOG_PIN  = 0;
  localparam logic [11:0] WAKE_VECTOR = 12'h004;
  localparam int          CLK_HZ      = 25000000;
  localparam int          CARRIER_HZ  = 38000;
  localparam int          CAR_HALF    = CLK_HZ / (2 * CARRIER_HZ);
  localparam logic [8:0]  CAR_HALF_M1 = 9'(CAR_HALF - 1);

  typedef struct packed {
    logic       dualEdge;
    logic       carrier;
    logic       schmitt;
    logic       amplifier;
    logic       highPd;
    logic [3:0] wakeEn;
    logic [3:0] medPd;
    logic [3:0] weakPd;
  } npw_opt_t;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic          wr;
    logic          rd;
  } npw_bus_t;

  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
    logic [3:0] weakPd;
    logic [3:0] medPd;
    logic [3:0] highPd;
    logic       schmittEn;
    logic       ampEn;
    logic       biasEn;
  } npw_pad_t;

  typedef struct packed {
    npw_opt_t    opt;
    logic [3:0]  dir;
    logic [3:0]  data;
    logic [3:0]  sync1;
    logic [3:0]  sync2;
    logic [3:0]  prev;
    logic [3:0]  stat;
    logic [3:0]  ien;
    logic [3:0]  rdata;
    logic [8:0]  carCnt;
    logic        carPh;
    npw_pad_t    pad;
    logic        wake;
    logic        pcLoad;
    logic [11:0] pcVector;
    logic        irq;
  } npw_state_t;
endpackage

// ===== verilog/npw_port.sv
// Purpose: Four-pin bidirectional port with halt wake-up, carrier and analog wake controls
// Assumes: mclk keeps running in halt; halt comes from core logic on mclk
// Notes:   Read data stands in the cycle after the read strobe
//
// Summary of operation
// - Each direction bit set makes its pin an output, clear makes an input.
// - Data writes update the output latch, which drives output pins.
// - Reading data returns the latch for output pins.
// - Reading data returns the sensed pin level for input pins.
// - Output pins always have their pull-downs off.
// - Input pins take weak, medium or no pull-down from their option bits.
// - High-value option redirects medium pull-down enables to the 220K resistor.
// - In halt, a rising edge on a wake-enabled pin wakes and loads 0x004.
// - Dual-edge option makes falling edges wake as well.
// - Carrier option drives 38KHz on output pin 3 while data bit 3 is one.
// - In halt, pin 3 output is forced low.
// - Without carrier option, pin 3 is an ordinary port pin outside halt.
// - Schmitt option enables the pin 0 Schmitt wake buffer after reset.
// - Amplifier option removes pin 0 pull-downs and holds pin 0 at bias.
// - Amplifier option enables the pin 0 amplifier wake block after reset.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module npw_port
  import npw_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rstn,
  input  wire npw_pkg::npw_bus_t bus,
  output logic [npw_pkg::DW-1:0] rdata,
  input  wire logic              halt,
  input  wire npw_pkg::npw_opt_t opt,
  input  wire logic [3:0]        pinIn,
  output npw_pkg::npw_pad_t      pad,
  output logic                   wakeReq,
  output logic                   pcLoad,
  output logic [11:0]            pcVector,
  output logic                   irq
);
  import npw_pkg::*;

  npw_state_t s;
  npw_state_t next_s;

  logic [3:0] rise;
  logic [3:0] fall;
  logic [3:0] edges;
  logic [3:0] clrMask;
  logic       carTick;
  logic       carOut;
  logic [3:0] drive;

  always_comb begin
    next_s  = s;
    rise    = s.sync2 & ~s.prev;
    fall    = ~s.sync2 & s.prev;
    // Edge set per pin, qualified by its own wake enable
    edges   = s.opt.wakeEn & (rise | (s.opt.dualEdge ? fall : 4'h0));
    clrMask = 4'h0;
    carTick = (s.carCnt == CAR_HALF_M1);

    // Two-stage synchroniser, then one stage of history for edges
    next_s.sync1 = pinIn;
    next_s.sync2 = s.sync1;
    next_s.prev  = s.sync2;

    // Register writes
    if (bus.wr) begin
      case (bus.addr)
        OFF_DIR:  next_s.dir = bus.wdata;
        OFF_DATA: next_s.data = bus.wdata;
        OFF_CLR:  clrMask = bus.wdata;
        OFF_IEN:  next_s.ien = bus.wdata;
        default:  ;
      endcase
    end

    // Read data, one cycle after the strobe; unmapped reads as zero
    next_s.rdata = 4'h0;
    if (bus.rd) begin
      case (bus.addr)
        OFF_DIR:  next_s.rdata = s.dir;
        OFF_DATA: next_s.rdata = (s.dir & s.data) | (~s.dir & s.sync2);
        OFF_STAT: next_s.rdata = s.stat;
        OFF_IEN:  next_s.rdata = s.ien;
        default:  next_s.rdata = 4'h0;
      endcase
    end

    // Sticky wake status: a new event wins over a clear in the same cycle
    next_s.stat = (s.stat & ~clrMask) | edges;
    next_s.irq  = |(next_s.stat & s.ien);

    // Wake from halt loads the fixed vector
    next_s.wake     = halt & (|edges);
    next_s.pcLoad   = halt & (|edges);
    next_s.pcVector = WAKE_VECTOR;

    // Carrier divider runs only while the carrier is asked for
    if (s.opt.carrier && s.dir[CARRIER_PIN] && s.data[CARRIER_PIN]) begin
      next_s.carCnt = carTick ? 9'h000 : s.carCnt + 9'h001;
      next_s.carPh  = carTick ? ~s.carPh : s.carPh;
    end else begin
      next_s.carCnt = 9'h000;
      next_s.carPh  = 1'b0;
    end
    carOut = s.data[CARRIER_PIN] & s.carPh;

    // Pin drive
    drive = s.data;
    if (s.opt.carrier) begin
      drive[CARRIER_PIN] = carOut;
    end
    if (halt) begin
      drive[CARRIER_PIN] = 1'b0;
    end
    next_s.pad.out = drive & s.dir;
    next_s.pad.oe  = s.dir;

    // Pull-downs only on inputs; high-value option redirects medium enables
    next_s.pad.weakPd = s.opt.weakPd & ~s.dir;
    next_s.pad.medPd  = s.opt.highPd ? 4'h0 : (s.opt.medPd & ~s.dir);
    next_s.pad.highPd = s.opt.highPd ? (s.opt.medPd & ~s.dir) : 4'h0;
    if (s.opt.amplifier) begin
      next_s.pad.weakPd[ANALOG_PIN] = 1'b0;
      next_s.pad.medPd[ANALOG_PIN]  = 1'b0;
      next_s.pad.highPd[ANALOG_PIN] = 1'b0;
    end
    next_s.pad.biasEn    = s.opt.amplifier;
    next_s.pad.ampEn     = s.opt.amplifier;
    next_s.pad.schmittEn = s.opt.schmitt;

    // Options never change after reset
    next_s.opt = s.opt;
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      s          <= '0;
      s.dir      <= DIR_RST;
      s.data     <= DATA_RST;
      s.ien      <= IEN_RST;
      s.stat     <= STAT_RST;
      s.pcVector <= WAKE_VECTOR;
      // Straps are caught on every clock while reset is held
      s.opt      <= opt;
    end else begin
      s <= next_s;
    end
  end

  assign rdata    = s.rdata;
  assign pad      = s.pad;
  assign wakeReq  = s.wake;
  assign pcLoad   = s.pcLoad;
  assign pcVector = s.pcVector;
  assign irq      = s.irq;

  // Checks
  a_dir_sets_oe: assert property (@(posedge mclk) disable iff (!rstn)
    $past(rstn) |-> pad.oe == $past(s.dir))
    else $error("output enable does not follow direction");

  a_out_latch_drive: assert property (@(posedge mclk) disable iff (!rstn)
    $past(rstn) && !$past(halt) && !$past(s.opt.carrier) |->
    pad.out == ($past(s.data) & $past(s.dir)))
    else $error("output pins do not carry the latch");

  a_read_data_mix: assert property (@(posedge mclk) disable iff (!rstn)
    bus.rd && bus.addr == OFF_DATA |=>
    rdata == (($past(s.dir) & $past(s.data)) | (~$past(s.dir) & $past(s.sync2))))
    else $error("data read mixes latch and pins wrongly");

  a_pin_read_sync: assert property (@(posedge mclk) disable iff (!rstn)
    bus.rd && bus.addr == OFF_DATA && s.dir == 4'h0 && $past(rstn, 3) |=>
    rdata == $past(pinIn, 3))
    else $error("input read is not the pin level two flops back");

  a_no_pd_output: assert property (@(posedge mclk) disable iff (!rstn)
    $past(rstn) |-> ((pad.weakPd | pad.medPd | pad.highPd) & $past(s.dir)) == 4'h0)
    else $error("pull-down left on an output pin");

  a_med_redirect: assert property (@(posedge mclk) disable iff (!rstn)
    $past(rstn) && s.opt.highPd |-> pad.medPd == 4'h0)
    else $error("medium pull-down on while high-value option set");

  a_wake_vector: assert property (@(posedge mclk) disable iff (!rstn)
    halt && |(s.opt.wakeEn & s.sync2 & ~s.prev) |=> pcLoad && wakeReq
    && pcVector == 12'h004)
    else $error("rising edge in halt did not wake to the vector");

  a_fall_dual: assert property (@(posedge mclk) disable iff (!rstn)
    halt && s.opt.dualEdge && |(s.opt.wakeEn & ~s.sync2 & s.prev) |=> pcLoad)
    else $error("falling edge did not wake in dual-edge mode");

  a_no_fall_single: assert property (@(posedge mclk) disable iff (!rstn)
    !s.opt.dualEdge && !(|(s.opt.wakeEn & s.sync2 & ~s.prev)) |=> !pcLoad)
    else $error("wake without a qualifying rising edge");

  a_carrier_half: assert property (@(posedge mclk) disable iff (!rstn)
    s.opt.carrier && s.dir[3] && s.data[3] && carTick |=> s.carPh != $past(s.carPh))
    else $error("carrier phase did not toggle at half period");

  a_halt_pin3_low: assert property (@(posedge mclk) disable iff (!rstn)
    halt ##1 $past(rstn) |-> !pad.out[3])
    else $error("pin 3 driven high in halt");

  a_amp_pin0: assert property (@(posedge mclk) disable iff (!rstn)
    $past(rstn) && s.opt.amplifier |->
    !pad.weakPd[0] && !pad.medPd[0] && !pad.highPd[0] && pad.biasEn && pad.ampEn)
    else $error("amplifier option left pin 0 pull-downs or bias wrong");

  a_schmitt_en: assert property (@(posedge mclk) disable iff (!rstn)
    $past(rstn) |-> pad.schmittEn == s.opt.schmitt)
    else $error("Schmitt buffer enable not from its option");

  a_opt_static: assert property (@(posedge mclk) disable iff (!rstn)
    $past(rstn) |-> $stable(s.opt))
    else $error("options changed after reset");

  a_irq_level: assert property (@(posedge mclk) disable iff (!rstn)
    $past(rstn) |-> irq == |($past(next_s.stat) & $past(s.ien)))
    else $error("interrupt does not follow enabled status");

  // Register bus side
  a_rdata_idle: assert property (@(posedge mclk) disable iff (!rstn)
    !bus.rd |=> rdata == 4'h0)
    else $error("read data not zero outside a read");

  a_read_dir: assert property (@(posedge mclk) disable iff (!rstn)
    bus.rd && bus.addr == OFF_DIR |=> rdata == $past(s.dir))
    else $error("direction read back wrong");

  a_read_ien: assert property (@(posedge mclk) disable iff (!rstn)
    bus.rd && bus.addr == OFF_IEN |=> rdata == $past(s.ien))
    else $error("interrupt enable read back wrong");

  a_read_clr_zero: assert property (@(posedge mclk) disable iff (!rstn)
    bus.rd && bus.addr == OFF_CLR |=> rdata == 4'h0)
    else $error("write-only clear register read as nonzero");

  a_dir_write: assert property (@(posedge mclk) disable iff (!rstn)
    bus.wr && bus.addr == OFF_DIR |=> s.dir == $past(bus.wdata))
    else $error("direction write did not land");

  a_data_write: assert property (@(posedge mclk) disable iff (!rstn)
    bus.wr && bus.addr == OFF_DATA |=> s.data == $past(bus.wdata))
    else $error("data write did not land in the latch");

  a_ien_write: assert property (@(posedge mclk) disable iff (!rstn)
    bus.wr && bus.addr == OFF_IEN |=> s.ien == $past(bus.wdata))
    else $error("interrupt enable write did not land");

  // Status and wake side
  a_stat_sticky: assert property (@(posedge mclk) disable iff (!rstn)
    !(bus.wr && bus.addr == OFF_CLR) |=> (s.stat & $past(s.stat)) == $past(s.stat))
    else $error("status bit lost without a clear");

  a_set_wins: assert property (@(posedge mclk) disable iff (!rstn)
    bus.wr && bus.addr == OFF_CLR && (edges & bus.wdata) != 4'h0 |=>
    (s.stat & $past(edges)) == $past(edges))
    else $error("clear beat a wake event in the same cycle");

  a_wake_needs_halt: assert property (@(posedge mclk) disable iff (!rstn)
    !halt |=> !wakeReq)
    else $error("wake request outside halt");

  a_wake_pc_pair: assert property (@(posedge mclk) disable iff (!rstn)
    wakeReq == pcLoad)
    else $error("wake request and vector load disagree");

  a_vector_const: assert property (@(posedge mclk) disable iff (!rstn)
    pcVector == WAKE_VECTOR)
    else $error("wake vector not the fixed address");

  a_no_wake_off: assert property (@(posedge mclk) disable iff (!rstn)
    halt && s.opt.wakeEn == 4'h0 |=> !wakeReq)
    else $error("wake from a pin without wake enable");

  a_sync_chain: assert property (@(posedge mclk) disable iff (!rstn)
    $past(rstn) |-> s.sync2 == $past(s.sync1))
    else $error("second synchroniser stage not fed by the first");

  a_irq_stat: assert property (@(posedge mclk) disable iff (!rstn)
    $past(rstn) |-> irq == |(s.stat & $past(s.ien)))
    else $error("interrupt does not match registered status");

  // Carrier side
  a_carrier_low: assert property (@(posedge mclk) disable iff (!rstn)
    $past(rstn) && s.opt.carrier && !$past(s.data[CARRIER_PIN]) |->
    !pad.out[CARRIER_PIN])
    else $error("pin 3 not low while its data bit is zero");

  a_carrier_idle: assert property (@(posedge mclk) disable iff (!rstn)
    !(s.opt.carrier && s.dir[CARRIER_PIN] && s.data[CARRIER_PIN]) |=>
    s.carCnt == 9'h000 && !s.carPh)
    else $error("carrier divider runs while not asked for");

  a_carcnt_range: assert property (@(posedge mclk) disable iff (!rstn)
    s.carCnt <= CAR_HALF_M1)
    else $error("carrier divider past its half period");

  // Pull-down and analog side
  a_weak_input: assert property (@(posedge mclk) disable iff (!rstn)
    $past(rstn) && !s.opt.amplifier |->
    pad.weakPd == (s.opt.weakPd & ~$past(s.dir)))
    else $error("weak pull-downs do not follow options and direction");

  a_high_redirect: assert property (@(posedge mclk) disable iff (!rstn)
    $past(rstn) && s.opt.highPd && !s.opt.amplifier |->
    pad.highPd == (s.opt.medPd & ~$past(s.dir)))
    else $error("high-value pull-downs do not take the medium enables");

  a_amp_blocks: assert property (@(posedge mclk) disable iff (!rstn)
    $past(rstn) |-> pad.ampEn == s.opt.amplifier && pad.biasEn == s.opt.amplifier)
    else $error("amplifier block or bias not from its option");

  c_wake_halt: cover property (@(posedge mclk) disable iff (!rstn) halt ##1 pcLoad);
  c_carrier_on: cover property (@(posedge mclk) disable iff (!rstn)
    s.opt.carrier && pad.out[3] && !halt);
  c_irq_clear: cover property (@(posedge mclk) disable iff (!rstn) irq ##[1:8] !irq);
  c_read_input: cover property (@(posedge mclk) disable iff (!rstn)
    bus.rd && bus.addr == OFF_DATA && s.dir != 4'hf);
endmodule
`default_nettype wire

// ===== verification/npw_pin_model.sv
// Purpose: Circuitry outside the four port pins
// Assumes: Bench drives a pin only where extEn is set
// Notes:   A pin with no drive and no pull-down shows the inverse of its last level
`timescale 1ns/1ns
`default_nettype none
module npw_pin_model
  import npw_pkg::*;
(
  input  wire logic              mclk,
  input  wire npw_pkg::npw_pad_t pad,
  input  wire logic [3:0]        extEn,
  input  wire logic [3:0]        extVal,
  output logic [3:0]             pinIn
);
  logic [3:0] last = 4'h0;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (pad.oe[i])
        pinIn[i] = pad.out[i];
      else if (extEn[i])
        pinIn[i] = extVal[i];
      else if (pad.weakPd[i] | pad.medPd[i] | pad.highPd[i])
        pinIn[i] = 1'b0;
      else
        pinIn[i] = ~last[i];
    end
  end
  always @(posedge mclk) last <= pinIn;
endmodule
`default_nettype wire

// ===== verification/tb.sv
// Purpose: Self-checking bench of the four-pin port
// Assumes: Random traffic from a fixed seed; corner cases by hand
// Notes:   Two option sets, one per reset
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin num_errors++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
  import npw_pkg::*;
  logic       mclk = 1'b0;
  logic       rstn = 1'b0;
  logic       halt = 1'b0;
  npw_bus_t   bus = '0;
  npw_opt_t   opt = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 4'hf, 4'h5, 4'ha};
  logic [3:0] extEn = 4'hf;
  logic [3:0] extVal = 4'h0;
  logic [3:0] rdata, pinIn, rv, dirV, datV;
  npw_pad_t   pad;
  logic       wakeReq, pcLoad, irq, seen;
  logic [11:0] pcVector;
  int         num_errors = 0;
  int         samples_checked = 0;
  int         n;

  always #20 mclk = ~mclk;

  npw_port u_dut (.mclk(mclk), .rstn(rstn), .bus(bus), .rdata(rdata), .halt(halt), .opt(opt),
    .pinIn(pinIn), .pad(pad), .wakeReq(wakeReq), .pcLoad(pcLoad), .pcVector(pcVector), .irq(irq));
  npw_pin_model u_pins (.mclk(mclk), .pad(pad), .extEn(extEn), .extVal(extVal), .pinIn(pinIn));

  function automatic logic [3:0] exp_read(input logic [3:0] d, input logic [3:0] l,
                                          input logic [3:0] p);
    return (d & l) | (~d & p);
  endfunction

  task automatic wr(input logic [7:0] a, input logic [3:0] d);
    @(posedge mclk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [3:0] d);
    @(posedge mclk);
    bus <= '{addr: a, wdata: 4'h0, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic do_reset(input npw_opt_t o);
    @(posedge mclk);
    rstn <= 1'b0;
    opt <= o;
    halt <= 1'b0;
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
  endtask

  // Drive the pins to v and watch eight cycles for a wake pulse
  task automatic edge_wait(input logic [3:0] v, output logic s);
    s = 1'b0;
    @(posedge mclk);
    extVal <= v;
    repeat (8) begin
      @(posedge mclk);
      #1;
      if (wakeReq === 1'b1) begin
        s = 1'b1;
        `CHK({pcLoad, pcVector}, {1'b1, WAKE_VECTOR})
      end
    end
  endtask

  task automatic gap(output int c);
    logic p;
    p = pad.out[3];
    c = 0;
    while (pad.out[3] === p && c < 800) begin
      @(posedge mclk);
      #1 c++;
    end
  endtask

  task automatic complete_run();
    $display("checks=%0d errors=%0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    complete_run();
  end

  initial begin
    void'($urandom(87183));
    do_reset(opt);
    @(posedge mclk);
    opt <= npw_opt_t'(17'($urandom));
    rd(OFF_DIR, rv);
    `CHK(rv, DIR_RST)
    `CHK({pad.schmittEn, pad.ampEn}, 2'b10)
    for (int k = 0; k < 8; k++) begin
      dirV = (k == 0) ? 4'hf : 4'($urandom);
      datV = 4'($urandom);
      @(posedge mclk);
      extVal <= 4'($urandom);
      wr(OFF_DIR, dirV);
      wr(OFF_DATA, datV);
      rd(OFF_DATA, rv);
      `CHK(pad.oe, dirV)
      `CHK(pad.out & dirV, datV & dirV)
      `CHK(rv & dirV, exp_read(dirV, datV, extVal) & dirV)
      `CHK(rv & ~dirV, exp_read(dirV, datV, extVal) & ~dirV)
      `CHK(pad.weakPd | pad.medPd | pad.highPd, 4'hf & ~dirV)
      `CHK({pad.weakPd, pad.medPd}, {4'ha & ~dirV, 4'h5 & ~dirV})
      `CHK(pad.schmittEn, 1'b1)
    end
    wr(OFF_DIR, 4'h8);
    wr(OFF_DATA, 4'h8);
    @(posedge mclk);
    halt <= 1'b1;
    repeat (2) @(posedge mclk);
    #1 `CHK(pad.out[3], 1'b0)
    @(posedge mclk);
    halt <= 1'b0;
    repeat (2) @(posedge mclk);
    #1 `CHK(pad.out[3], 1'b1)
    wr(OFF_DIR, 4'h0);
    edge_wait(4'h0, seen);
    wr(OFF_CLR, 4'hf);
    wr(OFF_IEN, 4'h2);
    @(posedge mclk);
    halt <= 1'b1;
    edge_wait(4'h2, seen);
    `CHK({seen, irq}, 2'b11)
    rd(OFF_STAT, rv);
    `CHK(rv, 4'h2)
    edge_wait(4'h0, seen);
    `CHK(seen, 1'b0)
    wr(OFF_IEN, 4'h0);
    @(posedge mclk);
    #1 `CHK(irq, 1'b0)
    wr(OFF_IEN, 4'h2);
    wr(OFF_CLR, 4'h2);
    rd(OFF_STAT, rv);
    `CHK({irq, rv}, 5'h00)
    rd(8'h1f, rv);
    `CHK(rv, 4'h0)
    do_reset('{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 4'hf, 4'hf, 4'hf});
    `CHK({pad.highPd, pad.medPd}, 8'he0)
    `CHK(pad.weakPd, 4'he)
    `CHK({pad.ampEn, pad.biasEn, pad.schmittEn}, 3'b110)
    @(posedge mclk);
    halt <= 1'b1;
    edge_wait(4'h4, seen);
    `CHK(seen, 1'b1)
    edge_wait(4'h0, seen);
    `CHK(seen, 1'b1)
    @(posedge mclk);
    halt <= 1'b0;
    wr(OFF_DIR, 4'h8);
    wr(OFF_DATA, 4'h8);
    gap(n);
    gap(n);
    `CHK(n, CAR_HALF)
    wr(OFF_DATA, 4'h0);
    repeat (3) @(posedge mclk);
    #1 `CHK(pad.out[3], 1'b0)
    complete_run();
  end
endmodule
`default_nettype wire
